// *** design/nvmc_pkg.sv ***
// package: register map, command codes and engine carriers of the nvm controller front end
`default_nettype none
package nvmc_pkg;
    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [3:0] IDX_COMMAND_CONTROL = 4'h0;
    localparam logic [3:0] IDX_SECTION_LOCK_CONTROL = 4'h1;
    localparam logic [3:0] IDX_CONTROLLER_STATUS = 4'h2;
    localparam logic [3:0] IDX_INTERRUPT_ENABLE = 4'h3;
    localparam logic [3:0] IDX_INTERRUPT_FLAG = 4'h4;
    localparam logic [3:0] IDX_WRITE_DATA_LO = 4'h6;
    localparam logic [3:0] IDX_WRITE_DATA_HI = 4'h7;
    localparam logic [3:0] IDX_TARGET_ADDR_LO = 4'h8;
    localparam logic [3:0] IDX_TARGET_ADDR_HI = 4'h9;
    localparam int ADDR_SHIFT = 2;
    localparam int IDX_W = 4;
    // ********************************************************
    // field positions and reset values
    // ********************************************************
    localparam int CMD_MSB = 2;
    localparam int BIT_APP_WP = 0;
    localparam int BIT_BOOT_LOCK = 1;
    localparam int BIT_PROG_BUSY = 0;
    localparam int BIT_EE_BUSY = 1;
    localparam int BIT_WRITE_FAULT = 2;
    localparam int BIT_EE_READY = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // protection window in retired instructions
    localparam logic [2:0] KEY_WINDOW = 3'h4;
    localparam int NUM_KEYS = 2;
    localparam int KEY_SPM = 0;
    localparam int KEY_IOREG = 1;
    // ********************************************************
    // commands
    // ********************************************************
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PAGE_WRITE = 3'h1,
        CMD_PAGE_ERASE = 3'h2,
        CMD_PAGE_ERASE_PROGRAM = 3'h3,
        CMD_BUFFER_CLEAR = 3'h4,
        CMD_FULL_ERASE = 3'h5,
        CMD_EEPROM_WIPE = 3'h6,
        CMD_FUSE_PROGRAM = 3'h7
    } nvmc_cmd_e;
    // request towards the memory engine
    typedef struct packed {
        nvmc_cmd_e cmd;
        logic to_eeprom;
        logic wipe_eeprom;
        logic [15:0] addr;
        logic [15:0] data;
    } nvmc_req_s;
    // report from the memory engine
    typedef struct packed {
        logic prog_busy;
        logic ee_busy;
        logic done;
        logic error;
        logic upd_valid;
        logic [15:0] upd_addr;
    } nvmc_rpt_s;
endpackage
`default_nettype wire

// *** design/nvmc_regs.sv ***
// module: register front end of the nvm controller, apb slave with command and lock logic
// ********************************************************
// Functional notes
// - command field write accepted only within four instructions of the key write
// - command codes: none, page write, erase, erase-write, clear, chip, eeprom, fuse
// - page commands pick program or eeprom memory from the address register
// - chip erase wipes eeprom too unless the preserve fuse is one
// - fuse write runs only when issued from the programming debug port
// - boot lock makes boot reads and fetches return zero
// - boot lock written only from boot code, reset clears, effective after leaving boot
// - app write protect can only be set, reset clears it
// - write fault flag reflects failure of the most recent operation
// - eeprom busy bit follows eeprom command execution
// - program busy bit follows program memory command execution
// - eeprom ready interrupt is a level gated by its enable
// - ready flag set while eeprom idle, cleared by writing one
// - data and address words appear as low then high byte registers
// - data word is the fuse write source value
// - address word holds the most recently updated location
// - interrupt request active while enabled and flag set
// ********************************************************
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module nvmc_regs #(
    parameter logic [15:0] EEPROM_BASE = 16'h8000,
    parameter logic [15:0] BOOT_END = 16'h0100
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu context
    input wire logic [1:0] key_written,
    input wire logic instr_retired,
    input wire logic exec_in_boot,
    input wire logic dbg_access,
    input wire logic eeprom_preserve_fuse,
    // boot section read path and app write protect
    input wire logic [15:0] mem_rdata,
    input wire logic [15:0] mem_raddr,
    output logic [15:0] mem_rdata_out,
    output logic boot_read_block,
    output logic app_write_block,
    // memory engine
    output nvmc_pkg::nvmc_req_s eng_req,
    output logic eng_start,
    input wire nvmc_pkg::nvmc_rpt_s eng_rpt,
    // interrupt
    output logic irq
);
    // refused at elaboration: a boot section reaching into eeprom breaks the target decode
    if (BOOT_END >= EEPROM_BASE) begin : g_bad_map
        $error("boot section must lie below the eeprom base");
    end

    // ********************************************************
    // apb decode
    // ********************************************************
    logic wr_en;
    logic rd_en;
    logic [nvmc_pkg::IDX_W-1:0] idx;
    logic mapped;
    logic [7:0] wbyte;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign idx = paddr[nvmc_pkg::ADDR_SHIFT +: nvmc_pkg::IDX_W];
    assign wbyte = pwdata[7:0];
    // zero wait states keep the cpu side simple
    assign pready = 1'b1;
    always_comb begin
        mapped = 1'b1;
        if (paddr[31:nvmc_pkg::ADDR_SHIFT+nvmc_pkg::IDX_W] != '0 ||
            paddr[nvmc_pkg::ADDR_SHIFT-1:0] != '0) begin
            mapped = 1'b0;
        end else begin
            unique case (idx)
                nvmc_pkg::IDX_COMMAND_CONTROL, nvmc_pkg::IDX_SECTION_LOCK_CONTROL,
                nvmc_pkg::IDX_CONTROLLER_STATUS, nvmc_pkg::IDX_INTERRUPT_ENABLE,
                nvmc_pkg::IDX_INTERRUPT_FLAG, nvmc_pkg::IDX_WRITE_DATA_LO,
                nvmc_pkg::IDX_WRITE_DATA_HI, nvmc_pkg::IDX_TARGET_ADDR_LO,
                nvmc_pkg::IDX_TARGET_ADDR_HI: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    end
    assign pslverr = psel & penable & ~mapped;
    logic wr_hit;
    assign wr_hit = wr_en & mapped;

    // ********************************************************
    // protection key windows
    // ********************************************************
    logic [2:0] key_cnt_ff [nvmc_pkg::NUM_KEYS];
    logic [nvmc_pkg::NUM_KEYS-1:0] key_open;
    genvar gk;
    generate
        for (gk = 0; gk < nvmc_pkg::NUM_KEYS; gk++) begin : g_key
            assign key_open[gk] = key_cnt_ff[gk] != 3'h0;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    key_cnt_ff[gk] <= 3'h0;
                end else if (key_written[gk]) begin
                    key_cnt_ff[gk] <= nvmc_pkg::KEY_WINDOW;
                end else if (instr_retired && key_open[gk]) begin
                    key_cnt_ff[gk] <= key_cnt_ff[gk] - 3'h1;
                end
            end
        end
    endgenerate

    // ********************************************************
    // command issue
    // ********************************************************
    logic cmd_wr;
    logic cmd_ok;
    nvmc_pkg::nvmc_cmd_e wr_cmd;
    nvmc_pkg::nvmc_cmd_e cmd_ff;
    logic [15:0] data_ff;
    logic [15:0] addr_ff;
    assign wr_cmd = nvmc_pkg::nvmc_cmd_e'(wbyte[nvmc_pkg::CMD_MSB:0]);
    assign cmd_wr = wr_hit & (idx == nvmc_pkg::IDX_COMMAND_CONTROL);
    // a fuse write from the cpu is refused outright
    assign cmd_ok = cmd_wr & key_open[nvmc_pkg::KEY_SPM] & (wr_cmd != nvmc_pkg::CMD_NONE) &
        ((wr_cmd != nvmc_pkg::CMD_FUSE_PROGRAM) | dbg_access);
    logic fuse_refused;
    assign fuse_refused = cmd_wr & key_open[nvmc_pkg::KEY_SPM] & ~dbg_access &
        (wr_cmd == nvmc_pkg::CMD_FUSE_PROGRAM);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= nvmc_pkg::CMD_NONE;
        end else if (cmd_ok) begin
            cmd_ff <= wr_cmd;
        end else if (eng_rpt.done) begin
            cmd_ff <= nvmc_pkg::CMD_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_start <= 1'b0;
            eng_req <= '0;
        end else begin
            eng_start <= cmd_ok;
            if (cmd_ok) begin
                eng_req.cmd <= wr_cmd;
                eng_req.to_eeprom <= (addr_ff >= EEPROM_BASE);
                eng_req.wipe_eeprom <= (wr_cmd == nvmc_pkg::CMD_EEPROM_WIPE) |
                    ((wr_cmd == nvmc_pkg::CMD_FULL_ERASE) & ~eeprom_preserve_fuse);
                eng_req.addr <= addr_ff;
                eng_req.data <= data_ff;
            end
        end
    end

    // ********************************************************
    // section locks
    // ********************************************************
    logic lock_wr;
    logic boot_lock_ff;
    logic boot_eff_ff;
    logic app_wp_ff;
    assign lock_wr = wr_hit & (idx == nvmc_pkg::IDX_SECTION_LOCK_CONTROL) &
        key_open[nvmc_pkg::KEY_IOREG];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_lock_ff <= 1'b0;
        end else if (lock_wr && exec_in_boot && wbyte[nvmc_pkg::BIT_BOOT_LOCK]) begin
            boot_lock_ff <= 1'b1;
        end
    end
    // the lock bites only once code has left boot, so boot may finish its work
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_eff_ff <= 1'b0;
        end else if (boot_lock_ff && !exec_in_boot) begin
            boot_eff_ff <= 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_wp_ff <= 1'b0;
        end else if (lock_wr && wbyte[nvmc_pkg::BIT_APP_WP]) begin
            app_wp_ff <= 1'b1;
        end
    end
    assign boot_read_block = boot_eff_ff;
    assign app_write_block = app_wp_ff;

    // boot reads and fetches are masked, one cycle of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rdata_out <= nvmc_pkg::RST_WORD;
        end else if (boot_eff_ff && mem_raddr < BOOT_END) begin
            mem_rdata_out <= nvmc_pkg::RST_WORD;
        end else begin
            mem_rdata_out <= mem_rdata;
        end
    end

    // ********************************************************
    // status and write fault
    // ********************************************************
    logic fault_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ff <= 1'b0;
        end else if (fuse_refused) begin
            fault_ff <= 1'b1;
        end else if (eng_rpt.done) begin
            fault_ff <= eng_rpt.error;
        end
    end

    // ********************************************************
    // interrupt
    // ********************************************************
    logic ie_ff;
    logic flag_ff;
    logic flag_clr;
    assign flag_clr = wr_hit & (idx == nvmc_pkg::IDX_INTERRUPT_FLAG) &
        wbyte[nvmc_pkg::BIT_EE_READY];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_ff <= 1'b0;
        end else if (wr_hit && idx == nvmc_pkg::IDX_INTERRUPT_ENABLE) begin
            ie_ff <= wbyte[nvmc_pkg::BIT_EE_READY];
        end
    end
    // set wins over clear: an idle eeprom keeps the flag up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else if (!eng_rpt.ee_busy) begin
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end
    assign irq = ie_ff & flag_ff;

    // ********************************************************
    // data and address words
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= nvmc_pkg::RST_WORD;
        end else if (wr_hit && idx == nvmc_pkg::IDX_WRITE_DATA_LO) begin
            data_ff[7:0] <= wbyte;
        end else if (wr_hit && idx == nvmc_pkg::IDX_WRITE_DATA_HI) begin
            data_ff[15:8] <= wbyte;
        end
    end
    // an engine update outranks a software byte write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff <= nvmc_pkg::RST_WORD;
        end else if (eng_rpt.upd_valid) begin
            addr_ff <= eng_rpt.upd_addr;
        end else if (wr_hit && idx == nvmc_pkg::IDX_TARGET_ADDR_LO) begin
            addr_ff[7:0] <= wbyte;
        end else if (wr_hit && idx == nvmc_pkg::IDX_TARGET_ADDR_HI) begin
            addr_ff[15:8] <= wbyte;
        end
    end

    // ********************************************************
    // read mux
    // ********************************************************
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && mapped) begin
            unique case (idx)
                nvmc_pkg::IDX_COMMAND_CONTROL: prdata[nvmc_pkg::CMD_MSB:0] = cmd_ff;
                nvmc_pkg::IDX_SECTION_LOCK_CONTROL: begin
                    prdata[nvmc_pkg::BIT_BOOT_LOCK] = boot_lock_ff;
                    prdata[nvmc_pkg::BIT_APP_WP] = app_wp_ff;
                end
                nvmc_pkg::IDX_CONTROLLER_STATUS: begin
                    prdata[nvmc_pkg::BIT_WRITE_FAULT] = fault_ff;
                    prdata[nvmc_pkg::BIT_EE_BUSY] = eng_rpt.ee_busy;
                    prdata[nvmc_pkg::BIT_PROG_BUSY] = eng_rpt.prog_busy;
                end
                nvmc_pkg::IDX_INTERRUPT_ENABLE: prdata[nvmc_pkg::BIT_EE_READY] = ie_ff;
                nvmc_pkg::IDX_INTERRUPT_FLAG: prdata[nvmc_pkg::BIT_EE_READY] = flag_ff;
                nvmc_pkg::IDX_WRITE_DATA_LO: prdata[7:0] = data_ff[7:0];
                nvmc_pkg::IDX_WRITE_DATA_HI: prdata[7:0] = data_ff[15:8];
                nvmc_pkg::IDX_TARGET_ADDR_LO: prdata[7:0] = addr_ff[7:0];
                nvmc_pkg::IDX_TARGET_ADDR_HI: prdata[7:0] = addr_ff[15:8];
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    AST_NOKEY_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && !key_open[nvmc_pkg::KEY_SPM]) |=> !eng_start)
        else $error("command accepted without key");
    AST_KEY_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && key_open[nvmc_pkg::KEY_SPM] && wr_cmd != nvmc_pkg::CMD_NONE &&
         wr_cmd != nvmc_pkg::CMD_FUSE_PROGRAM) |=> (eng_start && eng_req.cmd == $past(wr_cmd)))
        else $error("keyed command not started");
    AST_TARGET: assert property (@(posedge pclk) disable iff (!presetn)
        eng_start |-> eng_req.to_eeprom == (eng_req.addr >= EEPROM_BASE))
        else $error("wrong memory target");
    AST_WIPE: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_start && eng_req.cmd == nvmc_pkg::CMD_FULL_ERASE) |->
        eng_req.wipe_eeprom == !$past(eeprom_preserve_fuse))
        else $error("chip erase eeprom choice wrong");
    AST_FUSE_DBG: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_start && eng_req.cmd == nvmc_pkg::CMD_FUSE_PROGRAM) |-> $past(dbg_access))
        else $error("fuse write from cpu");
    AST_BOOT_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        (boot_eff_ff && mem_raddr < BOOT_END) |=> mem_rdata_out == 16'h0000)
        else $error("boot read not masked");
    AST_BOOT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        boot_lock_ff |=> boot_lock_ff)
        else $error("boot lock cleared");
    AST_APP_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        app_wp_ff |=> app_wp_ff)
        else $error("app protect cleared");
    AST_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_rpt.done && !fuse_refused) |=> fault_ff == $past(eng_rpt.error))
        else $error("write fault not tracking last op");
    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        !eng_rpt.ee_busy |=> flag_ff)
        else $error("ready flag not set while idle");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (ie_ff && flag_ff) [*2] |-> irq)
        else $error("interrupt request missing");
    AST_ADDR_UPD: assert property (@(posedge pclk) disable iff (!presetn)
        eng_rpt.upd_valid |=> addr_ff == $past(eng_rpt.upd_addr))
        else $error("address not updated");
endmodule
`default_nettype wire

// *** test/nvmc_engine_model.sv ***
// engine model: answers start requests with busy levels, a done pulse and an update report
`timescale 1ns/1ps
`default_nettype none
module nvmc_engine_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request side
    input wire logic eng_start,
    input wire nvmc_pkg::nvmc_req_s eng_req,
    // operation length and failure, set by the bench
    input wire logic [3:0] dly,
    input wire logic err_en,
    // report side
    output var nvmc_pkg::nvmc_rpt_s eng_rpt
);
    logic [3:0] cnt_ff;
    logic run_ff;
    logic ee_ff;
    logic done;
    logic [15:0] upd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
            run_ff <= 1'b0;
            ee_ff <= 1'b0;
        end else if (eng_start) begin
            run_ff <= 1'b1;
            cnt_ff <= dly;
            ee_ff <= eng_req.to_eeprom | (eng_req.cmd == nvmc_pkg::CMD_EEPROM_WIPE);
        end else if (run_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
            run_ff <= (cnt_ff != 4'h0);
        end
    end
    assign done = run_ff & (cnt_ff == 4'h0);
    // an offset address, so a copy of the request address is not mistaken for an update
    assign upd = eng_req.addr + 16'h0010;
    always_comb begin
        eng_rpt.prog_busy = run_ff & ~ee_ff;
        eng_rpt.ee_busy = run_ff & ee_ff;
        eng_rpt.done = done;
        eng_rpt.error = done & err_en;
        eng_rpt.upd_valid = done;
        // address lines carry nothing useful outside the valid pulse
        eng_rpt.upd_addr = done ? upd : ~upd;
    end
endmodule
`default_nettype wire

// *** test/nvm_controller_regs_bench.sv ***
// testbench: nvm controller register front end driven over apb beside an engine model
`timescale 1ns/1ps
`default_nettype none
module nvm_controller_regs_bench;
    // *****************
    // signals
    // *****************
    localparam logic [31:0] Z = 32'h0000_0000;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = Z, pwdata = Z, prdata, rd;
    logic pready, pslverr, er, instr_retired = 1'b0, exec_in_boot = 1'b0, dbg_access = 1'b0;
    logic keep_ee = 1'b0, err_en = 1'b0, boot_read_block, app_write_block, eng_start, irq;
    logic [1:0] key_written = 2'h0;
    logic [3:0] dly = 4'h4;
    logic [15:0] mem_rdata = 16'hbeef, mem_raddr = 16'h0000, mem_rdata_out;
    nvmc_pkg::nvmc_req_s eng_req, last_req;
    nvmc_pkg::nvmc_rpt_s eng_rpt;
    int err_total = 0, cmp_count = 0, starts = 0;
    always #12.5 pclk = ~pclk;
    nvmc_regs #(.EEPROM_BASE(16'h8000), .BOOT_END(16'h0100)) nvmc_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_written(key_written), .instr_retired(instr_retired), .exec_in_boot(exec_in_boot),
        .dbg_access(dbg_access), .eeprom_preserve_fuse(keep_ee), .mem_rdata(mem_rdata),
        .mem_raddr(mem_raddr), .mem_rdata_out(mem_rdata_out), .boot_read_block(boot_read_block),
        .app_write_block(app_write_block), .eng_req(eng_req), .eng_start(eng_start),
        .eng_rpt(eng_rpt), .irq(irq));
    nvmc_engine_model nvmc_engine_model_i (.pclk(pclk), .presetn(presetn),
        .eng_start(eng_start), .eng_req(eng_req), .dly(dly), .err_en(err_en),
        .eng_rpt(eng_rpt));
    always @(posedge pclk) begin
        if (eng_start === 1'b1) begin
            starts <= starts + 1;
            last_req <= eng_req;
        end
    end
    // *****************
    // shared tasks
    // *****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic hang;
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        end_of_test();
    endtask
    // one transfer, then an idle cycle so back-to-back calls never re-drive psel in one step
    task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {26'h000_0000, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, Z);
        chk(rd, exp);
    endtask
    task automatic key(input int b);
        key_written <= (b == 0) ? 2'h1 : 2'h2;
        @(posedge pclk);
        key_written <= 2'h0;
    endtask
    task automatic retire(input int n);
        instr_retired <= 1'b1;
        repeat (n) @(posedge pclk);
        instr_retired <= 1'b0;
    endtask
    task automatic issue(input logic [2:0] c);
        key(0);
        apb(1'b1, 4'h0, {29'h0000_0000, c});
        @(posedge pclk);
    endtask
    task automatic idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, 4'h2, Z);
            n++;
        end while (rd[1:0] !== 2'h0 && n < 40);
        if (n >= 40) hang();
    endtask
    task automatic set_addr(input logic [15:0] a);
        apb(1'b1, 4'h8, {24'h00_0000, a[7:0]});
        apb(1'b1, 4'h9, {24'h00_0000, a[15:8]});
    endtask
    // *****************
    // scenarios
    // *****************
    task automatic t_reset;
        for (int i = 0; i <= 10; i++) begin
            apb(1'b0, i[3:0], Z);
            chk(rd, (i == 4) ? 32'h0000_0001 : Z);
            chk({31'h0000_0000, er}, {31'h0000_0000, (i == 5 || i == 10)});
        end
    endtask
    task automatic t_data;
        logic [7:0] v [4] = '{8'h3c, 8'h5a, 8'h34, 8'h12};
        for (int i = 0; i < 4; i++) apb(1'b1, 4'(6 + i), 32'hffff_ff00 | 32'(v[i]));
        for (int i = 0; i < 4; i++) rdc(4'(6 + i), 32'(v[i]));
    endtask
    task automatic t_cmds;
        logic [2:0] c;
        int s;
        s = starts;
        apb(1'b1, 4'h0, 32'h0000_0001);
        key(0);
        retire(4);
        apb(1'b1, 4'h0, 32'h0000_0001);
        @(posedge pclk);
        chk(starts, s);
        set_addr(16'h8010);
        key(0);
        retire(3);
        apb(1'b1, 4'h0, 32'h0000_0002);
        @(posedge pclk);
        chk(starts, s + 1);
        chk({31'h0000_0000, last_req.to_eeprom}, 32'h0000_0001);
        chk({16'h0000, last_req.addr}, 32'h0000_8010);
        idle();
        set_addr(16'h0040);
        for (int i = 0; i < 8; i++) begin
            c = (i == 7) ? 3'h5 : i[2:0];
            keep_ee <= (i == 7);
            s = starts;
            issue(c);
            chk(starts, s + ((c != 3'h0) ? 1 : 0));
            if (c != 3'h0) chk({29'h0000_0000, last_req.cmd}, {29'h0000_0000, c});
            if (c < 3'h4 && c != 3'h0) chk({31'h0000_0000, last_req.to_eeprom}, Z);
            if (c == 3'h5) chk({31'h0000_0000, last_req.wipe_eeprom}, {31'h0, i != 7});
            idle();
        end
        rdc(4'h0, Z);
    endtask
    task automatic t_fuse;
        int s;
        s = starts;
        issue(3'h7);
        chk(starts, s);
        rdc(4'h2, 32'h0000_0004);
        dbg_access <= 1'b1;
        issue(3'h7);
        dbg_access <= 1'b0;
        chk(starts, s + 1);
        chk({16'h0000, last_req.data}, 32'h0000_5a3c);
        idle();
        rdc(4'h2, Z);
    endtask
    task automatic t_busy;
        dly <= 4'hc;
        set_addr(16'h8020);
        apb(1'b1, 4'h3, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        issue(3'h1);
        rdc(4'h2, 32'h0000_0002);
        apb(1'b1, 4'h4, 32'h0000_0001);
        rdc(4'h4, Z);
        chk({31'h0000_0000, irq}, Z);
        idle();
        rdc(4'h4, 32'h0000_0001);
        apb(1'b1, 4'h4, 32'h0000_0001);
        rdc(4'h4, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rdc(4'h8, 32'h0000_0030);
        rdc(4'h9, 32'h0000_0080);
        apb(1'b1, 4'h3, Z);
        chk({31'h0000_0000, irq}, Z);
        set_addr(16'h0040);
        err_en <= 1'b1;
        issue(3'h2);
        rdc(4'h2, 32'h0000_0001);
        idle();
        rdc(4'h2, 32'h0000_0004);
        err_en <= 1'b0;
        issue(3'h4);
        idle();
        rdc(4'h2, Z);
    endtask
    task automatic t_locks;
        apb(1'b1, 4'h1, 32'h0000_0001);
        rdc(4'h1, Z);
        key(1);
        apb(1'b1, 4'h1, 32'h0000_0001);
        rdc(4'h1, 32'h0000_0001);
        chk({31'h0000_0000, app_write_block}, 32'h0000_0001);
        key(1);
        apb(1'b1, 4'h1, Z);
        rdc(4'h1, 32'h0000_0001);
        key(1);
        apb(1'b1, 4'h1, 32'h0000_0003);
        rdc(4'h1, 32'h0000_0001);
        exec_in_boot <= 1'b1;
        mem_raddr <= 16'h0010;
        key(1);
        apb(1'b1, 4'h1, 32'h0000_0003);
        rdc(4'h1, 32'h0000_0003);
        chk({16'h0000, mem_rdata_out}, 32'h0000_beef);
        exec_in_boot <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({16'h0000, mem_rdata_out}, Z);
        chk({31'h0000_0000, boot_read_block}, 32'h0000_0001);
        mem_raddr <= 16'h0200;
        mem_rdata <= 16'h1234;
        repeat (2) @(posedge pclk);
        chk({16'h0000, mem_rdata_out}, 32'h0000_1234);
    endtask
    // *****************
    // main sequence
    // *****************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_data();
        t_cmds();
        t_fuse();
        t_busy();
        t_locks();
        end_of_test();
    end
endmodule
`default_nettype wire
